// *** rtl/ohrc_defines.svh ***
// Offsets, field positions, reset values of the revision and control registers
// Assumes a 32-bit register port with word offsets in bytes
`ifndef OHRC_DEFINES_SVH
`define OHRC_DEFINES_SVH
`define OHRC_OFS_SPEC_VERSION 8'h00
`define OHRC_OFS_MODE_CONTROL 8'h04
`define OHRC_SPEC_VERSION_VAL 8'h10
`define OHRC_CTRL_RESET 32'h0000_0000
`define OHRC_CTRL_WMASK 32'h0000_07FF
`define OHRC_POS_RATIO 0
`define OHRC_POS_PLE 2
`define OHRC_POS_IE 3
`define OHRC_POS_CLE 4
`define OHRC_POS_BLE 5
`define OHRC_POS_FS 6
`define OHRC_POS_IR 8
`define OHRC_POS_WC 9
`define OHRC_POS_WE 10
`define OHRC_POS_RD 3
`endif

// *** rtl/ohrc_pkg.sv ***
// Types shared by the revision and control register bank
// Assumes nothing beyond the defines header
package ohrc_pkg;
  typedef enum logic [1:0] {
    OHRC_STATE_RESET = 2'b00,
    OHRC_STATE_RESUME = 2'b01,
    OHRC_STATE_OPERATIONAL = 2'b10,
    OHRC_STATE_SUSPEND = 2'b11
  } ohrc_fstate_t;
endpackage

// *** rtl/ohrc_regs.sv ***
// Revision and operating-mode control registers of the host controller core
// Assumes a simple synchronous register port driven by the host bus interface
`include "ohrc_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module ohrc_regs #(
  // Register port widths
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and resets
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic SOFT_RESET,
  // Register port
  input wire logic REG_SEL,
  input wire logic REG_WR,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  output logic [DATA_W-1:0] REG_RDATA,
  // Hardware updates
  input wire logic HW_STATE_WR,
  input wire ohrc_pkg::ohrc_fstate_t HW_STATE,
  input wire logic HW_WC_WR,
  input wire logic HW_WC,
  // Events and status
  input wire logic INT_PENDING,
  input wire logic [31:0] INT_STATUS,
  // Outputs to the core
  output logic [1:0] SERVICE_RATIO,
  output logic PERIODIC_LIST_ENABLE,
  output logic ISOCHRONOUS_ENABLE,
  output logic CONTROL_LIST_ENABLE,
  output logic BULK_LIST_ENABLE,
  output ohrc_pkg::ohrc_fstate_t FUNCTIONAL_STATE,
  output logic HOST_IRQ,
  output logic MGMT_IRQ,
  output logic REMOTE_WAKEUP
);
  import ohrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Offsets 00h and 04h need three address bits; the decode compares at most eight
  if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ohrc_regs: ADDR_W must lie between 3 and 8");
  end

  // Both registers are whole 32-bit words
  if (DATA_W != 32) begin : g_bad_data_w
    $error("ohrc_regs: DATA_W must be 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Control register, the only writable state
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;

  // Registered read data, zero between reads
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Routed status interrupt lines
  logic host_irq_reg;
  logic host_irq_next;
  logic mgmt_irq_reg;
  logic mgmt_irq_next;

  // Remote wake-up request
  logic wake_reg;
  logic wake_next;

  // Decoded register accesses
  logic ctrl_wr;
  logic rd_en;

  // List enables picked out of the control register
  logic [3:0] list_en;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding functions

  // Address compare against a byte offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ofs[ADDR_W-1:0];
  endfunction

  // Value seen by a read at a given offset; unmapped offsets read zero
  function automatic logic [31:0] read_val(input logic [ADDR_W-1:0] a, input logic [31:0] c);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (hit(a, `OHRC_OFS_SPEC_VERSION)) begin
      // Fixed version byte, upper bits zero
      v = {24'h00_0000, `OHRC_SPEC_VERSION_VAL};
    end else if (hit(a, `OHRC_OFS_MODE_CONTROL)) begin
      v = c;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  // Only the control offset takes writes; the revision offset ignores them
  assign ctrl_wr = REG_SEL && REG_WR && hit(REG_ADDR, `OHRC_OFS_MODE_CONTROL);
  assign rd_en = REG_SEL && !REG_WR;

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  // Next value: soft reset first, then software, then hardware field updates
  always_comb begin
    ctrl_next = ctrl_reg;
    if (SOFT_RESET) begin
      // Keep wake connected only
      ctrl_next = `OHRC_CTRL_RESET;
      ctrl_next[`OHRC_POS_WC] = ctrl_reg[`OHRC_POS_WC];
    end else begin
      if (ctrl_wr) begin
        // Reserved bits held at zero
        ctrl_next = REG_WDATA[31:0] & `OHRC_CTRL_WMASK;
      end
      // Hardware beats a same-cycle software write for its own fields
      if (HW_STATE_WR) begin
        ctrl_next[`OHRC_POS_FS +: 2] = HW_STATE;
      end
      if (HW_WC_WR) begin
        ctrl_next[`OHRC_POS_WC] = HW_WC;
      end
    end
  end

  // Control register flops; hardware reset clears every bit
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= `OHRC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Answer one cycle after the read, zero otherwise
  always_comb begin
    rdata_next = '0;
    if (rd_en) begin
      rdata_next = DATA_W'(read_val(REG_ADDR, ctrl_reg));
    end
  end

  // Read data flops
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt routing

  // Pending status goes to exactly one line, chosen by the routing bit;
  // the wake enable bit takes no part here
  always_comb begin
    host_irq_next = INT_PENDING && !ctrl_next[`OHRC_POS_IR];
    mgmt_irq_next = INT_PENDING && ctrl_next[`OHRC_POS_IR];
  end

  // Interrupt line flops
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      host_irq_reg <= 1'b0;
      mgmt_irq_reg <= 1'b0;
    end else begin
      host_irq_reg <= host_irq_next;
      mgmt_irq_reg <= mgmt_irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote wake-up

  // Signalled while wake enable and resume detected are both set
  always_comb begin
    wake_next = ctrl_next[`OHRC_POS_WE] && INT_STATUS[`OHRC_POS_RD];
  end

  // Wake-up flop
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // List enables, one per control bit from bit 2 upward
  for (genvar g = 0; g < 4; g++) begin : g_list_en
    assign list_en[g] = ctrl_reg[`OHRC_POS_PLE + g];
  end

  // Every output comes straight from a flop
  assign REG_RDATA = rdata_reg;
  assign SERVICE_RATIO = ctrl_reg[`OHRC_POS_RATIO +: 2];
  assign PERIODIC_LIST_ENABLE = list_en[0];
  assign ISOCHRONOUS_ENABLE = list_en[1];
  assign CONTROL_LIST_ENABLE = list_en[2];
  assign BULK_LIST_ENABLE = list_en[3];
  assign FUNCTIONAL_STATE = ohrc_fstate_t'(ctrl_reg[`OHRC_POS_FS +: 2]);
  assign HOST_IRQ = host_irq_reg;
  assign MGMT_IRQ = mgmt_irq_reg;
  assign REMOTE_WAKEUP = wake_reg;
endmodule // ohrc_regs

// *** verif/ohrc_regs_sva.sv ***
// Checker for the revision and control register bank
// Assumes it is bound onto ohrc_regs
module ohrc_regs_chk (
  // Clock and resets
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic SOFT_RESET,
  // Register port
  input wire logic REG_SEL,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_RDATA,
  // Hardware updates and status
  input wire logic HW_STATE_WR,
  input wire ohrc_pkg::ohrc_fstate_t HW_STATE,
  input wire logic INT_PENDING,
  input wire logic [31:0] INT_STATUS,
  // Outputs of the bank
  input wire logic HOST_IRQ,
  input wire logic MGMT_IRQ,
  input wire logic REMOTE_WAKEUP,
  input wire logic BULK_LIST_ENABLE,
  input wire ohrc_pkg::ohrc_fstate_t FUNCTIONAL_STATE
);
  timeunit 1ns;
  timeprecision 1ns;
  import ohrc_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // Read request seen by the port
  wire rd = REG_SEL && !REG_WR;
  chk_rev_value: assert property (rd && REG_ADDR == 8'h00 |=> REG_RDATA == 32'h0000_0010)
    else $error("bad revision");
  chk_rev_nowrite: assert property (REG_SEL && REG_WR && REG_ADDR == 8'h00 ##2 rd && REG_ADDR == 8'h00
    |=> REG_RDATA == 32'h0000_0010) else $error("revision changed");
  chk_ctl_rsvd: assert property (rd && REG_ADDR == 8'h04 |=> REG_RDATA[31:11] == 21'h0)
    else $error("reserved bits set");
  chk_hw_state: assert property (HW_STATE_WR && !SOFT_RESET |=> FUNCTIONAL_STATE == $past(HW_STATE))
    else $error("state update lost");
  chk_wake_cause: assert property (REMOTE_WAKEUP |-> $past(INT_STATUS[3]))
    else $error("wake without resume");
  chk_irq_quiet: assert property (!INT_PENDING |=> !HOST_IRQ && !MGMT_IRQ)
    else $error("stray interrupt");
  chk_irq_route: assert property (HOST_IRQ |-> !MGMT_IRQ)
    else $error("both routes");
  chk_irq_reach: assert property (INT_PENDING |=> HOST_IRQ || MGMT_IRQ)
    else $error("interrupt lost");
  chk_soft_clear: assert property (SOFT_RESET |=> !BULK_LIST_ENABLE && FUNCTIONAL_STATE == OHRC_STATE_RESET)
    else $error("soft reset kept");
  cover property (rd && REG_ADDR == 8'h04);
  cover property (HW_STATE_WR);
  cover property (REMOTE_WAKEUP);
  cover property (MGMT_IRQ);
endmodule // ohrc_regs_chk
bind ohrc_regs ohrc_regs_chk chk_u (.*);

// *** verif/ohrc_regs_tb.sv ***
// Self-checking bench for the revision and control register bank
// Assumes the checker is compiled beside it
module ohrc_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ohrc_pkg::*;
  logic SYS_CLK = 0, RESET_N = 0, SOFT_RESET = 0, REG_SEL = 0, REG_WR = 0, HW_STATE_WR = 0;
  logic HW_WC_WR = 0, HW_WC = 0, INT_PENDING = 0, HOST_IRQ, MGMT_IRQ, REMOTE_WAKEUP;
  logic PERIODIC_LIST_ENABLE, ISOCHRONOUS_ENABLE, CONTROL_LIST_ENABLE, BULK_LIST_ENABLE;
  logic [1:0] SERVICE_RATIO;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 0, INT_STATUS = 0, REG_RDATA, rd, r, ctl, seed = 32'h0000_718e;
  ohrc_fstate_t HW_STATE = OHRC_STATE_RESET, FUNCTIONAL_STATE;
  int miscompares = 0, n_checks = 0, cyc = 0;
  ohrc_regs dut_u (.*);
  always #50 SYS_CLK = ~SYS_CLK;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One register access, read data captured after the answer edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    {REG_SEL, REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, w, a, d};
    @(posedge SYS_CLK);
    REG_SEL <= 0;
    #1 rd = REG_RDATA;
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  always @(posedge SYS_CLK) begin
    if (++cyc == 1000) begin
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RESET_N <= 1;
    acc(0, 8'h04, 0);
    chk(rd, 32'h0000_0000);
    acc(1, 8'h00, xs());
    acc(0, 8'h00, 0);
    chk(rd, 32'h0000_0010);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      r[7:6] = i[1:0];
      acc(1, 8'h04, r & 32'h0000_07ff);
      ctl = r & 32'h0000_07ff;
      acc(0, 8'h04, 0);
      chk(rd, ctl);
      chk(32'({FUNCTIONAL_STATE, BULK_LIST_ENABLE, CONTROL_LIST_ENABLE, ISOCHRONOUS_ENABLE,
        PERIODIC_LIST_ENABLE, SERVICE_RATIO}), 32'(ctl[7:0]));
      @(posedge SYS_CLK);
      {INT_PENDING, INT_STATUS} <= {r[12], r};
      repeat (2) @(posedge SYS_CLK);
      #1 chk(32'({HOST_IRQ, MGMT_IRQ, REMOTE_WAKEUP}), 32'({r[12] & ~ctl[8], r[12] & ctl[8], ctl[10] & r[3]}));
    end
    @(posedge SYS_CLK);
    {HW_STATE_WR, HW_WC_WR, HW_WC} <= 3'b111;
    HW_STATE <= OHRC_STATE_RESUME;
    @(posedge SYS_CLK);
    {HW_STATE_WR, HW_WC_WR} <= 2'b00;
    ctl[9] = 1;
    ctl[7:6] = 2'b01;
    acc(0, 8'h04, 0);
    chk(rd, ctl);
    @(posedge SYS_CLK);
    SOFT_RESET <= 1;
    INT_PENDING <= 1'b0;
    INT_STATUS <= 32'h0000_0000;
    @(posedge SYS_CLK);
    SOFT_RESET <= 0;
    acc(0, 8'h04, 0);
    chk(rd, 32'h0000_0200);
    // Hardware reset in mid-run clears wake connected as well
    @(posedge SYS_CLK);
    RESET_N <= 0;
    repeat (2) @(posedge SYS_CLK);
    RESET_N <= 1;
    acc(0, 8'h04, 0);
    chk(rd, 32'h0000_0000);
    chk(32'({HOST_IRQ, MGMT_IRQ, REMOTE_WAKEUP, FUNCTIONAL_STATE}), 32'h0000_0000);
    finish_test();
  end
endmodule // ohrc_regs_tb
